// File: rtl/karm_top.sv
// Control bank of an accelerator kernel: auto-restart counter, legacy restart and snapshot mailboxes.
//
// Behaviour
// - Counter written all ones runs the kernel continuously until stopped.
// - Counter written zero stops launching new executions.
// - Counter written N runs exactly N executions, then stops.
// - Zero written mid count cancels the remaining executions.
// - With the counter, completion sets only after the last run and idle.
// - Control bit 7 turns legacy restart on with 1, off with 0.
// - In legacy restart completion sets after every finished execution.
// - Counter register exists only when the build option is 1.
// - Mailbox option is none, input, output or both.
// - A present mailbox keeps a host copy and a kernel copy.
// - Input bit 0 at zero locks; kernel sees no updated inputs.
// - After unlock, host copy moves to kernel copy at next accept pulse.
// - Input bit 1 sets when bit 0 written zero, clears when taken.
// - Relock before the take cancels the pending transfer.
// - Mailboxes never stall host accesses or kernel execution.
// - Unlocked output copy refreshes freely; locked copy stays frozen.
// - Every output refresh clears output bit 1 to zero.
// - All bank registers run on the kernel core clock.
// - The port reset is active low regardless of global polarity.
// - Every register of the bundle shares one clock and reset.
// - Control word: start, completion, quiescent, accept, legacy at 0,1,2,3,7.
`timescale 1ns/1ns
module karm_top
  import karm_pkg::*;
#(
  parameter bit         RESTART_CNT = 1'b1,
  parameter karm_mbox_e MBOX_MODE   = KARM_MBOX_BOTH
) (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        port_rst_n_i,
  input  wire logic [5:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [5:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic             kern_start_o,
  input  wire logic        kern_done_i,
  input  wire logic        kern_idle_i,
  input  wire logic        kern_ready_i,
  output logic [31:0]      kern_arg_in_o,
  input  wire logic [31:0] kern_arg_out_i,
  input  wire logic        kern_arg_out_vld_i
);

  // ****************************************
  // Reset and bus handshake
  // ****************************************
  // Both resets are synchronous to the core clock, so no crossing is needed.
  logic rst;
  assign rst = sys_rst_i | ~port_rst_n_i;

  logic        awready_reg, arready_reg, bvalid_reg, rvalid_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic        aw_ok, ar_ok, wr_fire, rd_fire;
  logic [5:0]  waddr, raddr;

  // Ready never depends on lock state, so a locked mailbox cannot hold the bus.
  assign aw_ok   = s_axi_awvalid_i & s_axi_wvalid_i & ~awready_reg & ~bvalid_reg;
  assign ar_ok   = s_axi_arvalid_i & ~arready_reg & ~rvalid_reg;
  assign wr_fire = awready_reg & s_axi_awvalid_i & s_axi_wvalid_i;
  assign rd_fire = arready_reg & s_axi_arvalid_i;
  assign waddr   = {s_axi_awaddr_i[5:2], 2'h0};
  assign raddr   = {s_axi_araddr_i[5:2], 2'h0};

  // ****************************************
  // Address decode
  // ****************************************
  logic cnt_en, in_mb, out_mb;
  assign cnt_en = RESTART_CNT;
  assign in_mb  = (MBOX_MODE == KARM_MBOX_INPUT) | (MBOX_MODE == KARM_MBOX_BOTH);
  assign out_mb = (MBOX_MODE == KARM_MBOX_OUTPUT) | (MBOX_MODE == KARM_MBOX_BOTH);

  logic wr_ctrl, wr_cnt, wr_imb, wr_omb, wr_ain, wmap;
  assign wr_ctrl = wr_fire & (waddr == KARM_CTRL_OFS);
  assign wr_cnt  = wr_fire & (waddr == KARM_CNT_OFS) & cnt_en;
  assign wr_imb  = wr_fire & (waddr == KARM_IMB_OFS) & in_mb;
  assign wr_omb  = wr_fire & (waddr == KARM_OMB_OFS) & out_mb;
  assign wr_ain  = wr_fire & (waddr == KARM_AIN_OFS);
  assign wmap    = wr_ctrl | wr_cnt | wr_imb | wr_omb | wr_ain | (waddr == KARM_AOUT_OFS);

  logic lo_strb, wr_start, wr_leg;
  assign lo_strb  = s_axi_wstrb_i[0];
  assign wr_start = wr_ctrl & lo_strb & s_axi_wdata_i[KARM_START_BIT];
  assign wr_leg   = wr_ctrl & lo_strb;

  // ****************************************
  // Launch, restart counter and completion
  // ****************************************
  logic        start_reg, done_reg, legacy_reg, inflight_reg, ctr_run_reg;
  logic [31:0] cnt_reg;
  logic        start_next, done_next, legacy_next, inflight_next, ctr_run_next;
  logic [31:0] cnt_next, cnt_wr;
  logic        cnt_inf, cnt_dec, auto_go, ctr_fin, set_done, rd_ctrl;
  logic        host_go_reg, host_go_next;

  assign cnt_inf = &cnt_reg;
  assign cnt_dec = kern_done_i & ~cnt_inf & (cnt_reg != KARM_CNT_RST);
  assign cnt_wr  = karm_merge(cnt_reg, s_axi_wdata_i, s_axi_wstrb_i);
  assign cnt_next = wr_cnt ? cnt_wr : (cnt_reg - {31'h0, cnt_dec});

  assign inflight_next = kern_ready_i | (inflight_reg & ~kern_done_i);
  assign legacy_next   = wr_leg ? s_axi_wdata_i[KARM_LEGACY_BIT] : legacy_reg;

  // Launches still owed are the count minus the one already running.
  assign auto_go = legacy_next | (&cnt_next)
                 | (cnt_next > {31'h0, inflight_next});
  // Only a host start waits for the accept pulse, so a stop never lets one more launch through.
  assign host_go_next = wr_start | (host_go_reg & ~kern_ready_i);
  assign start_next   = auto_go | host_go_next;

  assign ctr_run_next = wr_cnt ? (cnt_wr != KARM_CNT_RST) | ctr_run_reg : ctr_run_reg & ~ctr_fin;
  assign ctr_fin  = ctr_run_reg & (cnt_reg == KARM_CNT_RST) & ~inflight_reg & kern_idle_i;
  assign set_done = legacy_reg ? kern_done_i
                  : (ctr_run_reg ? ctr_fin : kern_done_i);
  assign rd_ctrl  = rd_fire & (raddr == KARM_CTRL_OFS);
  // A completion in the same cycle as the clearing read survives.
  assign done_next = set_done | (done_reg & ~rd_ctrl);

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      start_reg    <= 1'b0;
      done_reg     <= 1'b0;
      legacy_reg   <= 1'b0;
      inflight_reg <= 1'b0;
      ctr_run_reg  <= 1'b0;
      host_go_reg  <= 1'b0;
      cnt_reg      <= KARM_CNT_RST;
    end else begin
      start_reg    <= start_next;
      done_reg     <= done_next;
      legacy_reg   <= legacy_next;
      inflight_reg <= inflight_next;
      ctr_run_reg  <= ctr_run_next & cnt_en;
      host_go_reg  <= host_go_next;
      cnt_reg      <= cnt_en ? cnt_next : KARM_CNT_RST;
    end
  end

  // ****************************************
  // Input mailbox
  // ****************************************
  logic        imb_unlock_reg, imb_pend_reg, imb_unlock_next, imb_pend_next;
  logic [31:0] ain_sw_reg, ain_hw_reg, ain_sw_next, ain_hw_next;
  logic        ilock_wr, take;

  assign ilock_wr = wr_imb & lo_strb & ~s_axi_wdata_i[KARM_UNLOCK_BIT];
  assign imb_unlock_next = (wr_imb & lo_strb) ? s_axi_wdata_i[KARM_UNLOCK_BIT] : imb_unlock_reg;
  // A relock in the take cycle wins, so the host never sees a half-applied update.
  assign take = imb_unlock_reg & imb_pend_reg & kern_ready_i & ~ilock_wr;
  assign imb_pend_next = ilock_wr | (imb_pend_reg & ~take);
  assign ain_sw_next = wr_ain ? karm_merge(ain_sw_reg, s_axi_wdata_i, s_axi_wstrb_i) : ain_sw_reg;
  // Without a mailbox the kernel copy loads the same next value as the host copy, in the same cycle.
  assign ain_hw_next = ~in_mb ? ain_sw_next : (take ? ain_sw_reg : ain_hw_reg);

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      imb_unlock_reg <= KARM_UNLOCK_RST;
      imb_pend_reg   <= 1'b0;
      ain_sw_reg     <= KARM_WORD_RST;
      ain_hw_reg     <= KARM_WORD_RST;
    end else begin
      imb_unlock_reg <= imb_unlock_next;
      imb_pend_reg   <= imb_pend_next & in_mb;
      ain_sw_reg     <= ain_sw_next;
      ain_hw_reg     <= ain_hw_next;
    end
  end

  // ****************************************
  // Output mailbox
  // ****************************************
  logic        omb_unlock_reg, omb_stat_reg, hw_new_reg;
  logic        omb_unlock_next, omb_stat_next, hw_new_next;
  logic [31:0] aout_hw_reg, aout_sw_reg, aout_sw_next;
  logic        olock_wr, refresh;

  assign olock_wr = wr_omb & lo_strb & ~s_axi_wdata_i[KARM_UNLOCK_BIT];
  assign omb_unlock_next = (wr_omb & lo_strb) ? s_axi_wdata_i[KARM_UNLOCK_BIT] : omb_unlock_reg;
  // Only the last kernel result made while locked is held and delivered after the unlock.
  assign refresh = hw_new_reg & (~out_mb | (omb_unlock_reg & ~olock_wr));
  assign hw_new_next = kern_arg_out_vld_i | (hw_new_reg & ~refresh);
  assign aout_sw_next = refresh ? aout_hw_reg : aout_sw_reg;
  assign omb_stat_next = olock_wr | (omb_stat_reg & ~refresh);

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      omb_unlock_reg <= KARM_UNLOCK_RST;
      omb_stat_reg   <= 1'b0;
      hw_new_reg     <= 1'b0;
      aout_hw_reg    <= KARM_WORD_RST;
      aout_sw_reg    <= KARM_WORD_RST;
    end else begin
      omb_unlock_reg <= omb_unlock_next;
      omb_stat_reg   <= omb_stat_next & out_mb;
      hw_new_reg     <= hw_new_next;
      aout_hw_reg    <= kern_arg_out_vld_i ? kern_arg_out_i : aout_hw_reg;
      aout_sw_reg    <= aout_sw_next;
    end
  end

  // ****************************************
  // Read data and responses
  // ****************************************
  logic [31:0] ctrl_word, imb_word, omb_word, rd_word;
  logic        rmap;
  assign ctrl_word = {24'h0, legacy_reg, 3'h0, kern_ready_i, kern_idle_i, done_reg, start_reg};
  assign imb_word  = {30'h0, imb_pend_reg, imb_unlock_reg & in_mb};
  assign omb_word  = {30'h0, omb_stat_reg, omb_unlock_reg & out_mb};
  assign rmap = (raddr == KARM_CTRL_OFS) | ((raddr == KARM_CNT_OFS) & cnt_en)
              | ((raddr == KARM_IMB_OFS) & in_mb) | ((raddr == KARM_OMB_OFS) & out_mb)
              | (raddr == KARM_AIN_OFS) | (raddr == KARM_AOUT_OFS);
  assign rd_word = (raddr == KARM_CTRL_OFS) ? ctrl_word
                 : (raddr == KARM_CNT_OFS)  ? cnt_reg
                 : ((raddr == KARM_IMB_OFS) & in_mb)  ? imb_word
                 : ((raddr == KARM_OMB_OFS) & out_mb) ? omb_word
                 : (raddr == KARM_AIN_OFS)  ? ain_sw_reg
                 : (raddr == KARM_AOUT_OFS) ? aout_sw_reg
                 : KARM_WORD_RST;

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      awready_reg <= 1'b0;
      arready_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      rvalid_reg  <= 1'b0;
      bresp_reg   <= KARM_RESP_OKAY;
      rresp_reg   <= KARM_RESP_OKAY;
      rdata_reg   <= KARM_WORD_RST;
    end else begin
      awready_reg <= aw_ok;
      arready_reg <= ar_ok;
      bvalid_reg  <= wr_fire | (bvalid_reg & ~s_axi_bready_i);
      rvalid_reg  <= rd_fire | (rvalid_reg & ~s_axi_rready_i);
      bresp_reg   <= wr_fire ? (wmap ? KARM_RESP_OKAY : KARM_RESP_SLVERR) : bresp_reg;
      rresp_reg   <= rd_fire ? (rmap ? KARM_RESP_OKAY : KARM_RESP_SLVERR) : rresp_reg;
      rdata_reg   <= rd_fire ? rd_word : rdata_reg;
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o  = awready_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rresp_o   = rresp_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign kern_start_o    = start_reg;
  assign kern_arg_in_o   = ain_hw_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking karm_cb @(posedge core_clk_i); endclocking
  default disable iff (rst);

  infinite_run_a: assert property (cnt_inf |-> kern_start_o)
    else $error("Infinite count without launch");

  stop_on_zero_a: assert property ((wr_cnt && s_axi_wstrb_i == 4'hF && s_axi_wdata_i == 32'h0)
    |=> (cnt_reg == 32'h0) && !$rose(kern_start_o))
    else $error("Zero count did not stop");

  stop_launch_a: assert property ((wr_cnt && cnt_wr == KARM_CNT_RST && !legacy_reg && !host_go_reg)
    |=> !kern_start_o)
    else $error("Launch kept after stop");

  count_step_a: assert property ((cnt_dec && !wr_cnt) |=> cnt_reg == $past(cnt_reg) - 32'h1)
    else $error("Counter did not step down");

  count_end_a: assert property ((cnt_reg == 32'h1 && inflight_reg && !legacy_reg
    && !wr_fire && !kern_done_i && !start_reg) |=> !kern_start_o)
    else $error("Extra launch past count");

  early_done_a: assert property ((ctr_run_reg && !ctr_fin && !legacy_reg && !done_reg)
    |=> !done_reg)
    else $error("Completion before last run");

  done_idle_a: assert property (($rose(done_reg) && $past(ctr_run_reg) && !$past(legacy_reg))
    |-> $past(kern_idle_i) && ($past(cnt_reg) == KARM_CNT_RST))
    else $error("Completion while kernel busy");

  legacy_done_a: assert property ((legacy_reg && kern_done_i) |=> done_reg)
    else $error("Legacy completion missed");

  legacy_bit_a: assert property (wr_leg |=> legacy_reg == $past(s_axi_wdata_i[KARM_LEGACY_BIT]))
    else $error("Legacy bit not stored");

  legacy_off_a: assert property ((wr_leg && !s_axi_wdata_i[KARM_LEGACY_BIT] && cnt_reg == KARM_CNT_RST
    && !wr_start && !host_go_reg) |=> !kern_start_o)
    else $error("Launch kept after legacy off");

  start_clear_a: assert property ((kern_ready_i && !auto_go && !wr_start) |=> !kern_start_o)
    else $error("Start not cleared on accept");

  in_locked_a: assert property ((in_mb && !imb_unlock_reg) |=> $stable(kern_arg_in_o))
    else $error("Kernel input changed while locked");

  in_take_a: assert property (take |=> kern_arg_in_o == $past(ain_sw_reg) && !imb_pend_reg)
    else $error("Input snapshot not taken");

  in_ready_a: assert property ((in_mb && !kern_ready_i) |=> $stable(kern_arg_in_o))
    else $error("Kernel input changed without accept");

  in_pend_a: assert property (ilock_wr |=> imb_pend_reg && !imb_unlock_reg ##1 imb_pend_reg)
    else $error("Pending bit not set by lock");

  relock_hold_a: assert property ((ilock_wr && imb_pend_reg) |=> $stable(kern_arg_in_o))
    else $error("Relock did not cancel transfer");

  out_frozen_a: assert property ((out_mb && !omb_unlock_reg) |=> $stable(aout_sw_reg))
    else $error("Output copy changed while locked");

  out_copy_a: assert property (refresh |=> aout_sw_reg == $past(aout_hw_reg))
    else $error("Output copy not refreshed");

  out_fresh_a: assert property ((refresh && out_mb) |=> !omb_stat_reg)
    else $error("Fresh status not cleared");

  no_stall_a: assert property (aw_ok |=> s_axi_awready_o ##1 !s_axi_awready_o)
    else $error("Write address stalled");

  read_stall_a: assert property (ar_ok |=> s_axi_arready_o ##1 !s_axi_arready_o)
    else $error("Read address stalled");

endmodule : karm_top

// File: rtl/karm_pkg.sv
// Shared constants and helpers for the kernel auto-restart and snapshot control bank.
package karm_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [5:0] KARM_CTRL_OFS = 6'h00;
  localparam logic [5:0] KARM_CNT_OFS  = 6'h10;
  localparam logic [5:0] KARM_IMB_OFS  = 6'h14;
  localparam logic [5:0] KARM_OMB_OFS  = 6'h18;
  localparam logic [5:0] KARM_AIN_OFS  = 6'h20;
  localparam logic [5:0] KARM_AOUT_OFS = 6'h28;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int KARM_START_BIT  = 0;
  localparam int KARM_DONE_BIT   = 1;
  localparam int KARM_IDLE_BIT   = 2;
  localparam int KARM_READY_BIT  = 3;
  localparam int KARM_LEGACY_BIT = 7;
  localparam int KARM_UNLOCK_BIT = 0;
  localparam int KARM_STAT_BIT   = 1;

  localparam logic [31:0] KARM_CNT_RST    = 32'h0000_0000;
  localparam logic [31:0] KARM_WORD_RST   = 32'h0000_0000;
  localparam logic        KARM_UNLOCK_RST = 1'b1;
  localparam logic [1:0]  KARM_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  KARM_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    KARM_MBOX_NONE,
    KARM_MBOX_INPUT,
    KARM_MBOX_OUTPUT,
    KARM_MBOX_BOTH
  } karm_mbox_e;

  function automatic logic [31:0] karm_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction : karm_merge

endpackage : karm_pkg

// File: tb/karm_kern_model.sv
// Behavioural kernel that answers the launch requests of the control bank.
`timescale 1ns/1ns
module karm_kern_model #(
  parameter int RUN_CYC = 4
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  output logic             ready_o,
  output logic             done_o,
  output logic             idle_o,
  output logic             vld_o,
  output logic [31:0]      out_o
);
  // ****************************************
  // Execution sequencer
  // ****************************************
  // Only one execution is in flight, so a launch request held high becomes back-to-back runs.
  int   cnt_reg;
  logic busy_reg;
  assign idle_o = ~busy_reg;
  always_ff @(posedge clk_i) begin
    ready_o <= 1'b0;
    done_o  <= 1'b0;
    vld_o   <= 1'b0;
    if (rst_i) begin
      busy_reg <= 1'b0;
      cnt_reg  <= 0;
      out_o    <= 32'h0;
    end else if (!busy_reg && start_i) begin
      busy_reg <= 1'b1;
      ready_o  <= 1'b1;
      cnt_reg  <= RUN_CYC;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 1;
      if (cnt_reg == 1) begin
        busy_reg <= 1'b0;
        done_o   <= 1'b1;
        vld_o    <= 1'b1;
        out_o    <= out_o + 32'h11;
      end
    end
  end
endmodule : karm_kern_model

// File: tb/tb_kernel_autorestart_mailbox.sv
// Self-checking bench for the kernel auto-restart and snapshot control bank.
`timescale 1ns/1ns
module tb_kernel_autorestart_mailbox
  import karm_pkg::*;
;
  // ****************************************
  // Stimulus, model and checks
  // ****************************************
  logic        clk, rst, prst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  resp;
  wire         awready, wready, bvalid, arready, rvalid, kstart, kdone, kidle, kready, kvld;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata, arg_in, arg_out;
  int          errors, checks_done, runs;

  karm_top DUT (
    .core_clk_i(clk), .sys_rst_i(rst), .port_rst_n_i(prst_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .kern_start_o(kstart), .kern_done_i(kdone), .kern_idle_i(kidle), .kern_ready_i(kready),
    .kern_arg_in_o(arg_in), .kern_arg_out_i(arg_out), .kern_arg_out_vld_i(kvld));

  karm_kern_model #(.RUN_CYC(4)) KERN (
    .clk_i(clk), .rst_i(rst), .start_i(kstart), .ready_o(kready), .done_o(kdone),
    .idle_o(kidle), .vld_o(kvld), .out_o(arg_out));

  // The port shares the core clock, so no crossing is needed.
  always #50 clk = ~clk;
  always @(posedge clk) if (kdone === 1'b1) runs <= runs + 1;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e, input string msg);
    rd(a);
    chk(v & m, e, msg);
  endtask : rchk

  task automatic t_reset();
    rchk(KARM_CNT_OFS, 32'hFFFFFFFF, KARM_CNT_RST, "counter reset");
    chk({30'h0, resp}, {30'h0, KARM_RESP_OKAY}, "counter read response");
    rchk(KARM_IMB_OFS, 32'h1, 32'h1, "input unlock reset");
    rchk(KARM_OMB_OFS, 32'h1, 32'h1, "output unlock reset");
    rchk(KARM_CTRL_OFS, 32'h4, 32'h4, "idle bit");
    $display("reset values test done");
  endtask : t_reset

  task automatic t_counted();
    int r0;
    r0 = runs;
    wr(KARM_CNT_OFS, 32'h3);
    chk({30'h0, resp}, {30'h0, KARM_RESP_OKAY}, "counter write response");
    tick(8);
    rchk(KARM_CTRL_OFS, 32'h2, 32'h0, "early completion");
    rd(KARM_CNT_OFS);
    for (int i = 0; i < 30 && v !== 32'h0; i++) rd(KARM_CNT_OFS);
    tick(12);
    chk(32'(runs - r0), 32'h3, "counted runs");
    rchk(KARM_CTRL_OFS, 32'h2, 32'h2, "completion after count");
    rchk(KARM_CTRL_OFS, 32'h2, 32'h0, "completion clear on read");
    $display("counted mode test done");
  endtask : t_counted

  task automatic t_infinite();
    int r0;
    r0 = runs;
    wr(KARM_CNT_OFS, 32'hFFFFFFFF);
    tick(60);
    rchk(KARM_CNT_OFS, 32'hFFFFFFFF, 32'hFFFFFFFF, "infinite count kept");
    chk(32'(runs - r0 > 5), 32'h1, "continuous runs");
    wr(KARM_CNT_OFS, 32'h0);
    chk({31'h0, kstart}, 32'h0, "no launch after stop");
    tick(20);
    r0 = runs;
    tick(40);
    chk(32'(runs - r0), 32'h0, "no runs after stop");
    $display("infinite mode test done");
  endtask : t_infinite

  task automatic t_abort();
    int r0;
    int r1;
    r0 = runs;
    wr(KARM_CNT_OFS, 32'h14);
    tick(20);
    wr(KARM_CNT_OFS, 32'h0);
    chk({31'h0, kstart}, 32'h0, "no launch after abort");
    tick(20);
    r1 = runs;
    tick(40);
    chk(32'(runs - r1), 32'h0, "no runs after abort");
    chk(32'(runs - r0 < 20), 32'h1, "abort cut the count");
    wr(KARM_CNT_OFS, 32'hFFFFFFFF);
    @(posedge clk);
    prst_n <= 1'b0;
    @(posedge clk);
    prst_n <= 1'b1;
    rchk(KARM_CNT_OFS, 32'hFFFFFFFF, 32'h0, "port reset clears counter");
    tick(20);
    $display("abort test done");
  endtask : t_abort

  task automatic t_legacy();
    int r0;
    rd(KARM_CTRL_OFS);
    wr(KARM_CTRL_OFS, 32'h80);
    tick(20);
    rchk(KARM_CTRL_OFS, 32'h82, 32'h82, "legacy on, completion set");
    tick(10);
    rchk(KARM_CTRL_OFS, 32'h2, 32'h2, "completion per run");
    wr(KARM_CTRL_OFS, 32'h0);
    tick(20);
    r0 = runs;
    tick(30);
    chk(32'(runs - r0), 32'h0, "legacy off stops runs");
    rchk(KARM_CTRL_OFS, 32'h80, 32'h0, "legacy bit off");
    $display("legacy restart test done");
  endtask : t_legacy

  task automatic t_inbox();
    wr(KARM_IMB_OFS, 32'h0);
    rchk(KARM_IMB_OFS, 32'h3, 32'h2, "pending on lock");
    wr(KARM_AIN_OFS, 32'hA5);
    wr(KARM_CTRL_OFS, 32'h1);
    tick(10);
    chk(arg_in, 32'h0, "locked input hidden");
    wr(KARM_IMB_OFS, 32'h1);
    wr(KARM_CTRL_OFS, 32'h1);
    tick(10);
    chk(arg_in, 32'hA5, "input taken at accept");
    rchk(KARM_IMB_OFS, 32'h3, 32'h1, "pending cleared");
    wr(KARM_IMB_OFS, 32'h0);
    wr(KARM_AIN_OFS, 32'h5A);
    wr(KARM_IMB_OFS, 32'h1);
    wr(KARM_IMB_OFS, 32'h0);
    wr(KARM_CTRL_OFS, 32'h1);
    tick(10);
    chk(arg_in, 32'hA5, "relock cancels transfer");
    wr(KARM_IMB_OFS, 32'h1);
    wr(KARM_CTRL_OFS, 32'h1);
    tick(10);
    chk(arg_in, 32'h5A, "transfer after unlock");
    $display("input snapshot test done");
  endtask : t_inbox

  task automatic t_outbox();
    logic [31:0] v0;
    wr(KARM_OMB_OFS, 32'h0);
    rchk(KARM_OMB_OFS, 32'h3, 32'h2, "output locked status");
    rd(KARM_AOUT_OFS);
    v0 = v;
    wr(KARM_CTRL_OFS, 32'h1);
    tick(10);
    rchk(KARM_AOUT_OFS, 32'hFFFFFFFF, v0, "locked output frozen");
    wr(KARM_OMB_OFS, 32'h1);
    wr(KARM_CTRL_OFS, 32'h1);
    tick(10);
    rchk(KARM_AOUT_OFS, 32'hFFFFFFFF, arg_out, "unlocked output refreshed");
    rchk(KARM_OMB_OFS, 32'h2, 32'h0, "refresh clears status");
    rd(6'h3C);
    chk({30'h0, resp}, {30'h0, KARM_RESP_SLVERR}, "unmapped read response");
    chk(v, 32'h0, "unmapped read data");
    wr(6'h3C, 32'hFFFFFFFF);
    chk({30'h0, resp}, {30'h0, KARM_RESP_SLVERR}, "unmapped write response");
    $display("output snapshot test done");
  endtask : t_outbox

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    prst_n = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = {6'h0, 6'h0, 32'h0, 4'hF};
    errors = 0;
    checks_done = 0;
    runs = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_counted();
    t_infinite();
    t_abort();
    t_legacy();
    t_inbox();
    t_outbox();
    complete_run();
  end

  // Whole sequence needs well under a thousand cycles; this leaves a wide margin.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule : tb_kernel_autorestart_mailbox
